// ===== src/ptm_regs.svh
// register map, field positions, reset values and counts of the timer
//
// Operation
// [R1] counter is readable as low byte bits 7..0 and high byte bits 1..0
// [R2] unused bits 7..2 of every high byte read as zero
// [R3] duty compare value is 10 bits, read/write, split low/high, resets zero
// [R4] period compare value is 10 bits, read/write, split low/high, resets zero
// [R5] mode 00 compare, 11 timer, 10 pwm or single pulse by pin action
// [R6] compare mode, select low: clear on period match or overflow, both flags
// [R7] compare mode, select high: clear on duty match, period flag never set
// [R8] software keeps duty value nonzero in compare mode
// [R9] compare mode pin changes only on duty match: high, low or toggle
// [R10] compare mode pin takes initial level when run bit rises
// [R11] timer mode counts like compare mode and leaves the pin undriven
// [R12] pwm clears on period match, duty sets width, select bit ignored
// [R13] pwm period equals period value, or 1024 when value is zero
// [R14] pwm output stays active all period when duty reaches the period
// [R15] pwm sets duty flag on duty match and period flag on period match
// [R16] pwm active level by initial bit, invert bit; actions 00/01 force
// [R17] single pulse starts on run rise, from software or trigger pin edge
// [R18] single pulse ends on run clear or duty match, which clears run
// [R19] single pulse clears counter only on run rise, ignores period match
// [R20] software sets pin action 11 for single pulse and keeps it
// [R21] run rise clears counter; run fall stops and keeps the count
// [R22] hold bit freezes the counter; clearing it resumes from there
// [R23] counter steps on each selected tick while running, wraps 1023 to 0
`ifndef PTM_REGS_SVH
`define PTM_REGS_SVH

// ----------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------
`define PTM_CTL0_OFS    8'h00
`define PTM_CTL1_OFS    8'h04
`define PTM_CNTL_OFS    8'h08
`define PTM_CNTH_OFS    8'h0c
`define PTM_DUTYL_OFS   8'h10
`define PTM_DUTYH_OFS   8'h14
`define PTM_PERL_OFS    8'h18
`define PTM_PERH_OFS    8'h1c
`define PTM_FLAG_OFS    8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PTM_C0_HOLD     7
`define PTM_C0_CKS_HI   6
`define PTM_C0_CKS_LO   4
`define PTM_C0_RUN      3
`define PTM_C1_SEL_HI   7
`define PTM_C1_SEL_LO   6
`define PTM_C1_ACT_HI   5
`define PTM_C1_ACT_LO   4
`define PTM_C1_INIT     3
`define PTM_C1_INV      2
`define PTM_C1_CLRSEL   0
`define PTM_FL_DUTY     0
`define PTM_FL_PER      1

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define PTM_CTL_RST     8'h00
`define PTM_CMP_RST     10'h000
`define PTM_DIV_SYS4    8'h03
`define PTM_DIV_H16     8'h0f
`define PTM_DIV_H64     8'h3f
`define PTM_DIV_TBC     8'hff

`endif

// ===== src/ptm_pkg.sv
// types shared by the timer modules
package ptm_pkg;

   typedef enum logic [1:0] {
      PTM_CMP = 2'h0,
      PTM_CAP = 2'h1,
      PTM_PWM = 2'h2,
      PTM_TMR = 2'h3
   } ptm_mode_e;

   typedef enum logic [2:0] {
      PTM_CK_SYS4 = 3'h0,
      PTM_CK_SYS  = 3'h1,
      PTM_CK_H16  = 3'h2,
      PTM_CK_H64  = 3'h3,
      PTM_CK_TBC  = 3'h4,
      PTM_CK_H    = 3'h5,
      PTM_CK_EXTR = 3'h6,
      PTM_CK_EXTF = 3'h7
   } ptm_cks_e;

   typedef struct packed {
      logic [7:0] div;
      logic       pin_prev;
   } ptm_tick_s;

   typedef struct packed {
      logic [9:0]  cnt;
      logic        hold;
      logic [2:0]  cks;
      logic        run;
      logic        run_prev;
      logic [7:0]  ctl1;
      logic [9:0]  duty;
      logic [9:0]  period;
      logic        aflag;
      logic        pflag;
      logic        lvl;
      logic        out;
      logic        oe;
      logic [31:0] rdata;
      logic        err;
   } ptm_state_s;

endpackage

// ===== src/ptm_tick.sv
// counter tick source and trigger pin edge detector
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.svh"
module ptm_tick (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] cks,
   input  wire logic       ext_pin,
   output logic            tick,
   output logic            trig
);
   ptm_pkg::ptm_tick_s s_reg;
   ptm_pkg::ptm_tick_s s_next;
   logic               rise;
   logic               fall;

   always_comb begin
      s_next          = s_reg;
      s_next.div      = s_reg.div + 8'h01;
      s_next.pin_prev = ext_pin;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rise = ext_pin & ~s_reg.pin_prev;
   assign fall = ~ext_pin & s_reg.pin_prev;
   // trigger edge follows the pin edge picked for counting, else rising
   assign trig = (cks == ptm_pkg::PTM_CK_EXTF) ? fall : rise;

   always_comb begin
      case (ptm_pkg::ptm_cks_e'(cks))
         ptm_pkg::PTM_CK_SYS4: tick = ((s_reg.div & `PTM_DIV_SYS4)
                                       == `PTM_DIV_SYS4);
         ptm_pkg::PTM_CK_H16:  tick = ((s_reg.div & `PTM_DIV_H16)
                                       == `PTM_DIV_H16);
         ptm_pkg::PTM_CK_H64:  tick = ((s_reg.div & `PTM_DIV_H64)
                                       == `PTM_DIV_H64);
         ptm_pkg::PTM_CK_TBC:  tick = (s_reg.div == `PTM_DIV_TBC);
         ptm_pkg::PTM_CK_EXTR: tick = rise;
         ptm_pkg::PTM_CK_EXTF: tick = fall;
         default:              tick = 1'b1;
      endcase
   end
endmodule
`default_nettype wire

// ===== src/ptm_core.sv
// 10-bit periodic timer with apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.svh"
module ptm_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_clock_trigger_pin,
   output logic             timer_output_pin,
   output logic             timer_output_pin_oe,
   output logic             duty_match_flag,
   output logic             period_match_flag
);
   ptm_pkg::ptm_state_s s_reg;
   ptm_pkg::ptm_state_s s_next;
   logic                tick;
   logic                trig;
   logic                wr;
   logic                setup;
   logic [1:0]          sel;
   logic [1:0]          act;
   logic                init;
   logic                inv;
   logic                clrsel;
   logic                rise;
   logic                step;
   logic [9:0]          cnt_inc;
   logic                am;
   logic                pm;
   logic                single;
   logic                full;
   logic                active;
   logic                hit;

   ptm_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .cks     (s_reg.cks),
      .ext_pin (ext_clock_trigger_pin),
      .tick    (tick),
      .trig    (trig)
   );

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   assign wr      = psel & penable & pwrite;
   assign setup   = psel & ~penable;
   assign sel     = s_reg.ctl1[`PTM_C1_SEL_HI:`PTM_C1_SEL_LO];
   assign act     = s_reg.ctl1[`PTM_C1_ACT_HI:`PTM_C1_ACT_LO];
   assign init    = s_reg.ctl1[`PTM_C1_INIT];
   assign inv     = s_reg.ctl1[`PTM_C1_INV];
   assign clrsel  = s_reg.ctl1[`PTM_C1_CLRSEL];
   assign single  = (sel == ptm_pkg::PTM_PWM) && (act == 2'h3); // [R5]
   assign rise    = s_reg.run & ~s_reg.run_prev;
   assign step    = tick & s_reg.run & s_reg.run_prev & ~s_reg.hold; // [R22]
   assign cnt_inc = s_reg.cnt + 10'h001; // [R23]
   // matches look at the next count, so period p gives p ticks and zero
   // matches at the wrap, giving 1024
   assign am      = cnt_inc == s_reg.duty;
   assign pm      = cnt_inc == s_reg.period; // [R13]

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.run_prev = s_reg.run;
      s_next.err      = 1'b0;
      hit             = 1'b0;
      full            = 1'b0;
      active          = 1'b0;

      // software writes
      if (wr) begin
         case (paddr)
            `PTM_CTL0_OFS: begin
               s_next.hold = pwdata[`PTM_C0_HOLD];
               s_next.cks  = pwdata[`PTM_C0_CKS_HI:`PTM_C0_CKS_LO];
               s_next.run  = pwdata[`PTM_C0_RUN];
            end
            `PTM_CTL1_OFS:  s_next.ctl1 = pwdata[7:0];
            `PTM_DUTYL_OFS: s_next.duty[7:0] = pwdata[7:0]; // [R3]
            `PTM_DUTYH_OFS: s_next.duty[9:8] = pwdata[1:0]; // [R3]
            `PTM_PERL_OFS:  s_next.period[7:0] = pwdata[7:0]; // [R4]
            `PTM_PERH_OFS:  s_next.period[9:8] = pwdata[1:0]; // [R4]
            `PTM_FLAG_OFS: begin
               s_next.aflag = s_reg.aflag & ~pwdata[`PTM_FL_DUTY];
               s_next.pflag = s_reg.pflag & ~pwdata[`PTM_FL_PER];
            end
            `PTM_CNTL_OFS, `PTM_CNTH_OFS: s_next.err = 1'b0;
            default: s_next.err = 1'b1;
         endcase
      end

      // trigger pin edge raises the run bit in single pulse mode
      if (single && !s_reg.run && trig) begin
         s_next.run = 1'b1; // [R17]
      end

      // counter
      if (rise) begin
         s_next.cnt = `PTM_CMP_RST; // [R21] [R19]
         s_next.lvl = init; // [R10]
      end else if (step) begin
         s_next.cnt = cnt_inc; // [R23]
         case (ptm_pkg::ptm_mode_e'(sel))
            ptm_pkg::PTM_PWM: begin
               if (single) begin
                  if (am) begin
                     s_next.aflag = 1'b1; // [R18]
                     s_next.run   = 1'b0; // [R18]
                  end
               end else begin
                  if (pm) begin
                     s_next.cnt   = `PTM_CMP_RST; // [R12]
                     s_next.pflag = 1'b1; // [R15]
                  end
                  if (am) begin
                     s_next.aflag = 1'b1; // [R15]
                  end
               end
            end
            default: begin
               if (clrsel && sel != ptm_pkg::PTM_CAP) begin
                  if (am) begin
                     s_next.cnt = `PTM_CMP_RST; // [R7]
                  end
               end else begin
                  if (pm) begin
                     s_next.cnt   = `PTM_CMP_RST; // [R6]
                     s_next.pflag = 1'b1; // [R6] [R11]
                  end
               end
               if (am) begin
                  s_next.aflag = 1'b1; // [R6] [R7] [R11]
                  hit          = sel == ptm_pkg::PTM_CMP;
               end
            end
         endcase
      end

      // compare mode pin action on duty match only
      if (hit) begin
         case (act)
            2'h1:    s_next.lvl = 1'b0; // [R9]
            2'h2:    s_next.lvl = 1'b1; // [R9]
            2'h3:    s_next.lvl = ~s_reg.lvl; // [R9]
            default: s_next.lvl = s_reg.lvl; // [R9]
         endcase
      end

      // pwm and single pulse level, active level set by init bit
      full   = (s_next.period != 10'h000) && (s_next.duty >= s_next.period);
      active = full || (s_next.cnt < s_next.duty); // [R14]
      case (ptm_pkg::ptm_mode_e'(s_next.ctl1[`PTM_C1_SEL_HI:`PTM_C1_SEL_LO]))
         ptm_pkg::PTM_PWM: begin
            case (s_next.ctl1[`PTM_C1_ACT_HI:`PTM_C1_ACT_LO])
               2'h0:    s_next.out = ~s_next.ctl1[`PTM_C1_INIT]; // [R16]
               2'h1:    s_next.out = s_next.ctl1[`PTM_C1_INIT]; // [R16]
               2'h2:    s_next.out = ~(active ^ s_next.ctl1[`PTM_C1_INIT]);
               default: s_next.out = ~(s_next.run ^ s_next.ctl1[`PTM_C1_INIT]);
            endcase
            s_next.oe = 1'b1;
         end
         ptm_pkg::PTM_CMP: begin
            s_next.out = s_next.lvl;
            s_next.oe  = 1'b1;
         end
         default: begin
            s_next.out = 1'b0;
            s_next.oe  = 1'b0; // [R11]
         end
      endcase
      s_next.out = s_next.out ^ s_next.ctl1[`PTM_C1_INV]; // [R16]

      // read data captured in the setup phase, answered in the access phase
      if (setup) begin
         case (psel ? paddr : 8'h00)
            `PTM_CTL0_OFS:  s_next.rdata = {24'h000000, s_reg.hold,
                                            s_reg.cks, s_reg.run, 3'h0};
            `PTM_CTL1_OFS:  s_next.rdata = {24'h000000, s_reg.ctl1};
            `PTM_CNTL_OFS:  s_next.rdata = {24'h000000, s_reg.cnt[7:0]}; // [R1]
            `PTM_CNTH_OFS:  s_next.rdata = {30'h0, s_reg.cnt[9:8]}; // [R1] [R2]
            `PTM_DUTYL_OFS: s_next.rdata = {24'h000000, s_reg.duty[7:0]};
            `PTM_DUTYH_OFS: s_next.rdata = {30'h0, s_reg.duty[9:8]}; // [R2]
            `PTM_PERL_OFS:  s_next.rdata = {24'h000000, s_reg.period[7:0]};
            `PTM_PERH_OFS:  s_next.rdata = {30'h0, s_reg.period[9:8]}; // [R2]
            `PTM_FLAG_OFS:  s_next.rdata = {30'h0, s_reg.pflag, s_reg.aflag};
            default:        s_next.rdata = 32'h00000000;
         endcase
         s_next.err = 1'b0;
         if (!pwrite) begin
            case (paddr)
               `PTM_CTL0_OFS, `PTM_CTL1_OFS, `PTM_CNTL_OFS, `PTM_CNTH_OFS,
               `PTM_DUTYL_OFS, `PTM_DUTYH_OFS, `PTM_PERL_OFS, `PTM_PERH_OFS,
               `PTM_FLAG_OFS: s_next.err = 1'b0;
               default:       s_next.err = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg        <= '0;
         s_reg.ctl1   <= `PTM_CTL_RST;
         s_reg.duty   <= `PTM_CMP_RST;
         s_reg.period <= `PTM_CMP_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign pready              = 1'b1;
   assign prdata              = s_reg.rdata;
   // a write error shows in its own access cycle, a read error from setup
   assign pslverr             = psel & penable & (pwrite ? s_next.err
                                                         : s_reg.err);
   assign timer_output_pin    = s_reg.out;
   assign timer_output_pin_oe = s_reg.oe;
   assign duty_match_flag     = s_reg.aflag;
   assign period_match_flag   = s_reg.pflag;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   hi_byte_zero_a: assert property ( // [R2]
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite &&
      (paddr == `PTM_CNTH_OFS || paddr == `PTM_PERH_OFS)
      |-> prdata[31:2] == 30'h0)
      else $error("high byte upper bits not zero");

   run_rise_clr_a: assert property ( // [R21]
      @(posedge pclk) disable iff (!presetn)
      $rose(s_reg.run) |=> s_reg.cnt == 10'h000)
      else $error("counter not cleared on run rise");

   stop_keep_a: assert property ( // [R21]
      @(posedge pclk) disable iff (!presetn)
      !s_reg.run |=> s_reg.cnt == $past(s_reg.cnt))
      else $error("counter moved while stopped");

   hold_freeze_a: assert property ( // [R22]
      @(posedge pclk) disable iff (!presetn)
      s_reg.hold && s_reg.run && s_reg.run_prev |=> $stable(s_reg.cnt))
      else $error("counter moved while held");

   timer_no_drive_a: assert property ( // [R11]
      @(posedge pclk) disable iff (!presetn)
      (s_reg.ctl1[7:6] == 2'h3) [*2] |-> !timer_output_pin_oe)
      else $error("pin driven in timer mode");

   pulse_end_a: assert property ( // [R18]
      @(posedge pclk) disable iff (!presetn)
      single && step && am && !wr |=> !s_reg.run && s_reg.aflag)
      else $error("single pulse not ended by duty match");

   no_period_flag_a: assert property ( // [R7] [R11]
      @(posedge pclk) disable iff (!presetn)
      (sel == 2'h0 || sel == 2'h3) && clrsel && !s_reg.pflag && !wr
      |=> !s_reg.pflag)
      else $error("period flag set with duty clear select");

   pwm_full_a: assert property ( // [R14]
      @(posedge pclk) disable iff (!presetn)
      (sel == 2'h2 && act == 2'h2 && s_reg.period != 10'h000 &&
       s_reg.duty >= s_reg.period) [*2]
      |-> timer_output_pin == (init ^ inv))
      else $error("pwm not fully active");

   pwm_period_a: assert property ( // [R12] [R15]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h2 && !single && step && pm && !wr
      |=> s_reg.cnt == 10'h000 && s_reg.pflag)
      else $error("pwm period match missed");

   duty_hi_zero_a: assert property ( // [R2]
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && paddr == `PTM_DUTYH_OFS
      |-> prdata[31:2] == 30'h0)
      else $error("duty high byte upper bits not zero");

   cmp_init_lvl_a: assert property ( // [R10]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h0 && rise |=> s_reg.lvl == $past(init))
      else $error("pin not set to initial level");

   cmp_pin_keep_a: assert property ( // [R9]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h0 && !hit && !rise |=> $stable(s_reg.lvl))
      else $error("pin level moved without duty match");

   cmp_clear_p_a: assert property ( // [R6]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h0 && !clrsel && step && pm
      |=> s_reg.cnt == 10'h000 && s_reg.pflag)
      else $error("period match did not clear counter");

   cnt_step_a: assert property ( // [R23]
      @(posedge pclk) disable iff (!presetn)
      step && !am && !pm |=> s_reg.cnt == $past(cnt_inc))
      else $error("counter did not step by one");

   pwm_duty_flag_a: assert property ( // [R15]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h2 && !single && step && am |=> s_reg.aflag)
      else $error("pwm duty flag not set");

   pwm_forced_a: assert property ( // [R16]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h2 && act == 2'h1
      |-> timer_output_pin == (init ^ inv))
      else $error("pwm pin not forced active");

   pwm_idle_a: assert property ( // [R16]
      @(posedge pclk) disable iff (!presetn)
      sel == 2'h2 && act == 2'h0
      |-> timer_output_pin == !(init ^ inv))
      else $error("pwm pin not forced inactive");

   trig_run_a: assert property ( // [R17]
      @(posedge pclk) disable iff (!presetn)
      single && !s_reg.run && trig |=> s_reg.run)
      else $error("trigger edge did not start pulse");

   pulse_skip_p_a: assert property ( // [R19]
      @(posedge pclk) disable iff (!presetn)
      single && step && pm && !am
      |=> s_reg.cnt == $past(cnt_inc))
      else $error("single pulse cleared on period match");
endmodule
`default_nettype wire

// ===== testbench/ptm_pin_partner.sv
// far-side model: load on the timer output pin and trigger pin source
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_partner (
   input  wire logic pclk,
   input  wire logic trig_req,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      trig_pin,
   output logic      pin_seen
);
   // pull-down load: an undriven pin settles low
   assign pin_seen = pin_oe ? pin_out : 1'b0;

   // one clean rising edge per request, held three cycles
   initial begin
      trig_pin = 1'b0;
      forever begin
         @(posedge trig_req);
         @(posedge pclk);
         trig_pin <= 1'b1;
         repeat (3) @(posedge pclk);
         trig_pin <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/periodic_timer_10bit_tb_top.sv
// self-checking bench of the periodic timer with its apb registers
`timescale 1ns/1ps
`default_nettype none
`include "ptm_regs.svh"
module periodic_timer_10bit_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, trig_req = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, trig_pin, pin_out, pin_oe, pin_seen;
   logic        aflag, pflag;
   int          n_fail = 0, comparisons = 0, cyc = 0;
   localparam logic [7:0] RUN = 8'h18, HOLD = 8'h98, OFF = 8'h10;

   always #50 pclk = ~pclk;

   ptm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clock_trigger_pin(trig_pin), .timer_output_pin(pin_out),
      .timer_output_pin_oe(pin_oe), .duty_match_flag(aflag),
      .period_match_flag(pflag));

   ptm_pin_partner partner_u (.pclk(pclk), .trig_req(trig_req),
      .pin_out(pin_out), .pin_oe(pin_oe), .trig_pin(trig_pin),
      .pin_seen(pin_seen));

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // apb master
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic r(input logic [7:0] a, output logic [31:0] rd);
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
   endtask

   task automatic rcnt(output logic [9:0] c);
      logic [31:0] lo, hi;
      r(`PTM_CNTL_OFS, lo);
      r(`PTM_CNTH_OFS, hi);
      c = {hi[1:0], lo[7:0]};
   endtask

   task automatic s10(input logic [7:0] a, input logic [9:0] v);
      w(a, {24'h0, v[7:0]});
      w(a + 8'h04, {30'h0, v[9:8]});
   endtask

   function automatic logic [7:0] c1(logic [1:0] m, logic [1:0] a,
                                     logic i, logic v, logic c);
      return {m, a, i, v, 1'b0, c};
   endfunction

   function automatic int pwm_hi(int du, int per, int n, logic v);
      int on;
      on = (du >= per) ? per : du;
      return n * (v ? per - on : on);
   endfunction

   task automatic go(input logic [7:0] ctl, input logic [9:0] du, pe);
      w(`PTM_CTL0_OFS, {24'h0, OFF});
      w(`PTM_CTL1_OFS, {24'h0, ctl});
      s10(`PTM_DUTYL_OFS, du);
      s10(`PTM_PERL_OFS, pe);
      w(`PTM_FLAG_OFS, 32'h3);
      w(`PTM_CTL0_OFS, {24'h0, RUN});
   endtask

   task automatic cnt_hi(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge pclk);
         h += (pin_seen === 1'b1);
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   logic [7:0]  regs [6] = '{`PTM_CNTL_OFS, `PTM_CNTH_OFS, `PTM_DUTYL_OFS,
                             `PTM_DUTYH_OFS, `PTM_PERL_OFS, `PTM_PERH_OFS};
   logic [31:0] d, v;
   logic [9:0]  c, c2, mx, du, pe;
   logic [7:0]  a;
   logic        e;
   int          h, per, n;
   logic [3:0]  act_exp = 4'b0101;

   initial begin
      void'($urandom(53));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) begin
         r(regs[i], d);
         chk("reset value", d, 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         a = regs[2 + i % 4];
         v = $urandom;
         w(a, {24'h0, v[7:0]});
         r(a, d);
         chk("rw byte", d, a[2] ? {30'h0, v[1:0]} : {24'h0, v[7:0]});
      end
      w(`PTM_CNTL_OFS, 32'hff);
      r(`PTM_CNTL_OFS, d);
      chk("counter read only", d, 32'h0);
      apb(1'b0, 8'h24, 32'h0, d, e);
      chk("unmapped err", e, 1'b1);
      chk("unmapped data", d, 32'h0);
      // compare mode: every pin action, initial level high
      for (int k = 0; k < 4; k++) begin
         go(c1(ptm_pkg::PTM_CMP, k[1:0], 1'b1, 1'b0, 1'b0),
            10'd30, 10'd100);
         repeat (10) @(posedge pclk);
         chk("cmp init", pin_seen, 1'b1);
         repeat (40) @(posedge pclk);
         chk("cmp action", pin_seen, act_exp[k]);
         repeat (70) @(posedge pclk);
         chk("cmp pin after p", pin_seen, act_exp[k]);
         chk("cmp aflag", aflag, 1'b1);
         chk("cmp pflag", pflag, 1'b1);
      end
      mx = 0;
      repeat (20) begin
         rcnt(c);
         if (c > mx) mx = c;
      end
      chk("cmp clear on p", mx < 10'd100, 1'b1);
      // timer mode, clear on duty match with period below duty
      go(c1(ptm_pkg::PTM_TMR, 2'b00, 1'b1, 1'b0, 1'b1), 10'd40, 10'd10);
      mx = 0;
      repeat (20) begin
         rcnt(c);
         if (c > mx) mx = c;
      end
      chk("tmr pin released", pin_oe, 1'b0);
      chk("clear on a", mx < 10'd40, 1'b1);
      chk("p ignored", mx >= 10'd10, 1'b1);
      chk("no pflag", pflag, 1'b0);
      chk("tmr aflag", aflag, 1'b1);
      w(`PTM_CTL0_OFS, {24'h0, HOLD});
      rcnt(c);
      rcnt(c2);
      chk("hold freezes", c2, c);
      w(`PTM_CTL0_OFS, {24'h0, RUN});
      rcnt(c2);
      chk("resume", ((c2 + 10'd40 - c) % 10'd40) inside {[1:14]}, 1'b1);
      w(`PTM_CTL0_OFS, {24'h0, OFF});
      rcnt(c);
      rcnt(c2);
      chk("stop keeps", c2, c);
      // pwm with random period and duty, last one period value zero
      for (int i = 0; i < 5; i++) begin
         pe = (i == 4) ? 10'd0 : 10'(8 + $urandom % 33);
         du = (i == 4) ? 10'd512 : 10'(1 + $urandom % (pe + 4));
         if (i == 3) du = pe; // duty equal to period corner
         per = (pe == 0) ? 1024 : int'(pe);
         n = (i == 4) ? 1 : 3;
         go(c1(ptm_pkg::PTM_PWM, 2'b10, 1'b1, i[0], 1'($urandom)), du, pe);
         repeat (per * 2 + 5) @(posedge pclk);
         cnt_hi(per * n, h);
         chk("pwm on", h, pwm_hi(du, per, n, i[0]));
         chk("pwm aflag", aflag, int'(du) <= per);
         chk("pwm pflag", pflag, 1'b1);
      end
      for (int k = 0; k < 2; k++) begin
         go(c1(ptm_pkg::PTM_PWM, k[1:0], 1'b1, 1'b0, 1'b0), 10'd5, 10'd10);
         repeat (30) @(posedge pclk);
         cnt_hi(20, h);
         chk("pwm forced", h, 20 * k);
      end
      // single pulse from the trigger pin, then from software
      w(`PTM_CTL0_OFS, {24'h0, OFF});
      w(`PTM_CTL1_OFS, {24'h0, c1(ptm_pkg::PTM_PWM, 2'b11, 1'b1, 1'b0, 1'b0)});
      s10(`PTM_DUTYL_OFS, 10'd25);
      s10(`PTM_PERL_OFS, 10'd5);
      w(`PTM_FLAG_OFS, 32'h3);
      trig_req <= 1'b1;
      @(posedge pclk);
      trig_req <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("pulse lead", pin_seen, 1'b1);
      rcnt(c);
      chk("pulse past p", c > 10'd5, 1'b1);
      repeat (40) @(posedge pclk);
      r(`PTM_CTL0_OFS, d);
      chk("pulse run cleared", d[3], 1'b0);
      chk("pulse trail", pin_seen, 1'b0);
      chk("pulse aflag", aflag, 1'b1);
      rcnt(c);
      chk("pulse stop count", c, 10'd25);
      w(`PTM_CTL0_OFS, {24'h0, RUN});
      repeat (3) @(posedge pclk);
      chk("sw pulse lead", pin_seen, 1'b1);
      rcnt(c);
      chk("restart clears", c < 10'd25, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
